/* rtl/ahpc_regs.svh */
// Constants of the converter host port: status layout and timing counts.
// Assumes inclusion by bare name; definitions only.
`ifndef AHPC_REGS_SVH
`define AHPC_REGS_SVH

// Status word bit positions
`define AHPC_ST_DONE 0
`define AHPC_ST_RSV1 1
`define AHPC_ST_BYTE 2
`define AHPC_ST_ACQ 3
`define AHPC_ST_RSV4 4
`define AHPC_ST_TRACK 5
`define AHPC_ST_CONV 6
`define AHPC_ST_CAL 7
`define AHPC_STATUS_RESET 8'h81
`define AHPC_RESULT_RESET 16'h0000

// Timing counts in master clock cycles; trim counts in conversions, resolution in bits
`define AHPC_DIV_CYCLES 4
`define AHPC_EXTRA_CYCLES 20
`define AHPC_ACQ_CYCLES 15
`define AHPC_EOC_PULSE 4
`define AHPC_SER_DELAY 4
`define AHPC_CAL_STD 1441020
`define AHPC_CAL_FAST 58280
`define AHPC_TRIM_STD 72051
`define AHPC_TRIM_FAST 2014
`define AHPC_RES_BITS 16

`endif

/* rtl/ahpc_pkg.sv */
// Types shared by the converter host port modules.
// Assumes nothing of its surroundings.
package ahpc_pkg;

  typedef enum logic [1:0] {
    st_cal,
    st_track,
    st_conv,
    st_extra
  } ahpc_state_type;

endpackage : ahpc_pkg

/* rtl/ahpc_sync.sv */
// Two-stage synchroniser for pins entering the mclk domain.
// Assumes each bit is a slow level; no word coherence is kept.
`timescale 1ns/1ns
module ahpc_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
)(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Pins and synchronised copies
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  if (WIDTH < 1)
  begin : g_bad_width
    $error("ahpc_sync needs WIDTH of at least one");
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg <= RST_VAL;
      sync_out <= RST_VAL;
    end
    else
    begin
      meta_reg <= pin_in;
      sync_out <= meta_reg;
    end
  end

endmodule : ahpc_sync

/* rtl/ahpc_serial_out.sv */
// Serial result output: delays each decided bit and strobes it out.
// Assumes decisions arrive no closer than every four cycles.
`timescale 1ns/1ns
`include "ahpc_regs.svh"
module ahpc_serial_out #(
  parameter int DELAY = `AHPC_SER_DELAY
)(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Bit decisions
  input wire logic bit_valid,
  input wire logic bit_value,
  // Serial pins
  output logic serial_bit_out,
  output logic bit_strobe_out
);

  logic [DELAY-2:0] vpipe_reg;
  logic [DELAY-2:0] bpipe_reg;
  logic upd_reg;
  logic upd_d_reg;

  if (DELAY < 2)
  begin : g_bad_delay
    $error("ahpc_serial_out needs DELAY of at least two");
  end

  // Bit lands on the pin DELAY cycles after its decision
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      vpipe_reg <= '0;
      bpipe_reg <= '0;
      serial_bit_out <= 1'b0;
      upd_reg <= 1'b0;
    end
    else
    begin
      vpipe_reg <= (DELAY-1)'({vpipe_reg, bit_valid});
      bpipe_reg <= (DELAY-1)'({bpipe_reg, bit_value});
      upd_reg <= vpipe_reg[DELAY-2];
      if (vpipe_reg[DELAY-2])
        serial_bit_out <= bpipe_reg[DELAY-2]; // RULE22
    end
  end

  // Strobe is driven off the pin update, not the decision, so the final
  // bit still gets a rising edge after the conversion ends
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      upd_d_reg <= 1'b0;
      bit_strobe_out <= 1'b1;
    end
    else
    begin
      upd_d_reg <= upd_reg;
      bit_strobe_out <= !(upd_reg || upd_d_reg); // RULE23
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  strobe_data_stable_a: // RULE23
    assert property ($fell(bit_strobe_out) |->
      $stable(serial_bit_out) ##1 $stable(serial_bit_out) ##1
      (bit_strobe_out && $stable(serial_bit_out)))
    else $error("serial data moved while strobe was low");

  serial_delay_a: // RULE22
    assert property (bit_valid |-> ##DELAY
      (serial_bit_out == $past(bit_value, DELAY)))
    else $error("serial bit not presented after the set delay");

endmodule : ahpc_serial_out

/* rtl/ahpc_ctrl.sv */
// Converter host port: calibration control, status, result readout,
// end-of-convert and serial output of a self-calibrating SAR converter.
// Assumes all pin inputs are asynchronous to mclk; the comparator decision
// comes from the analog core; the bus wire is resolved outside.
// Operation
// RULE1: Any reset starts exactly one full calibration cycle.
// RULE2: Host should avoid burst calibration; reset calibration is preferred.
// RULE3: Interleave adds one experiment per conversion, trim updates per set.
// RULE4: Interleave starts with trim pin and select low; adds 20 cycles. Here the unlatched trim pin low starts it even with select high.
// RULE5: Once chosen, interleave should run continuously, not intermittently.
// RULE6: Select and strobe low drive result (port high) or status (low).
// RULE7: Host polls busy by masking status with 01000000.
// RULE8: Status read while hold strobe low is a software reset.
// RULE9: Ready goes low when a conversion ends with valid data.
// RULE10: Ready returns high within four cycles of data read or start.
// RULE11: Status bit 0 falls at conversion end, rises on next read.
// RULE12: Status bits 1 and 4 are reserved.
// RULE13: Status bit 2 shows which byte the next read returns.
// RULE14: Bits 3,5,6,7 show acquired, tracking, converting, calibrating.
// RULE15: Word mode presents the full result left-justified on D15 down.
// RULE16: Byte mode gives upper byte first, then zero-padded lower byte.
// RULE17: Byte reads keep alternating until the next conversion ends.
// RULE18: Result is buffered; reads never disturb a conversion.
// RULE19: Standalone ties select and strobe low; outputs always driven.
// RULE20: Free-running needs width high, trim low, hold strobed or looped.
// RULE21: Standalone ready pulses low for four cycles per conversion.
// RULE22: Serial bits go out MSB first, four cycles after decision.
// RULE23: Bit strobe falls after decision, rises when serial data stable.
// RULE24: Select, port and hold low together cause a software reset.
// RULE25: Trim inputs pass latches that close when select goes high. Here the background trim pin also acts unlatched.
// RULE26: Acquired falls fifteen cycles after ready falls.
// RULE27: Hard clear empties all logic, then a full calibration runs. Here the result buffer and serial pipeline keep their contents.
// RULE28: Reserved status bits always read as zero.
`timescale 1ns/1ns
`include "ahpc_regs.svh"
module ahpc_ctrl #(
  parameter int RES_BITS = `AHPC_RES_BITS,
  parameter int CAL_CYCLES = `AHPC_CAL_STD,
  parameter int TRIM_CONVERSIONS = `AHPC_TRIM_STD
)(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Host strobes and control pins
  input wire logic hard_clear,
  input wire logic device_select_n,
  input wire logic output_strobe_n,
  input wire logic port_select,
  input wire logic sample_strobe_n,
  input wire logic word_width_sel,
  input wire logic trim_request,
  input wire logic background_trim_n,
  // Analog core
  input wire logic comp_decision,
  // Data bus pins
  output logic [15:0] data_out,
  output logic data_oe_n,
  // Event and serial pins
  output logic result_ready_n,
  output logic acquired_n,
  output logic serial_bit_out,
  output logic bit_strobe_out
);

  localparam int CW = $clog2(CAL_CYCLES + 1);
  localparam int TW = $clog2(TRIM_CONVERSIONS + 1);

  if (RES_BITS != 12 && RES_BITS != 14 && RES_BITS != 16)
  begin : g_bad_res
    $error("RES_BITS must be 12, 14 or 16");
  end
  if (CAL_CYCLES < 2 || TRIM_CONVERSIONS < 2)
  begin : g_bad_counts
    $error("calibration counts must be at least two");
  end

  function automatic logic [15:0] set_bit(input logic [15:0] word,
                                          input logic [3:0] pos,
                                          input logic val);
    logic [15:0] res;
    res = word;
    res[pos] = val;
    return res;
  endfunction : set_bit

  logic [8:0] sync_vec;
  logic hclr_s;
  logic cs_n_s;
  logic rd_n_s;
  logic ps_s;
  logic hold_n_s;
  logic bw_s;
  logic cal_s;
  logic ilv_n_s;
  logic comp_s;

  ahpc_sync #(
    .WIDTH(9),
    .RST_VAL(9'h0FA)
  ) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .pin_in({hard_clear, device_select_n, output_strobe_n, port_select,
             sample_strobe_n, word_width_sel, trim_request,
             background_trim_n, comp_decision}),
    .sync_out(sync_vec)
  );

  assign {hclr_s, cs_n_s, rd_n_s, ps_s, hold_n_s, bw_s, cal_s, ilv_n_s,
          comp_s} = sync_vec;

  ahpc_pkg::ahpc_state_type state_reg;
  logic [CW-1:0] cal_cnt_reg;
  logic burst_reg;
  logic [3:0] bit_idx_reg;
  logic [15:0] sar_reg;
  logic [15:0] result_reg;
  logic [4:0] extra_cnt_reg;
  logic [TW-1:0] trim_cnt_reg;
  logic trim_update_reg;
  logic [1:0] div_reg;
  logic trim_lat_reg;
  logic ilv_n_lat_reg;
  logic rd_prev_reg;
  logic rd_ps_reg;
  logic [1:0] eoc_cnt_reg;
  logic [3:0] acq_cnt_reg;
  logic byte_ptr_reg;
  logic done_flag_reg;
  logic [7:0] status;
  logic [3:0] pos;

  wire sel_rd = !cs_n_s && !rd_n_s;
  wire soft_rst = !cs_n_s && !ps_s && !hold_n_s; // RULE8 RULE24
  wire clear = hclr_s || soft_rst; // RULE27
  wire tick = (div_reg == 2'(`AHPC_DIV_CYCLES - 1));
  wire ilv_act = !ilv_n_lat_reg || !ilv_n_s; // RULE4
  wire rd_start = sel_rd && !rd_prev_reg;
  wire data_rd = rd_start && ps_s;
  wire data_rd_end = !sel_rd && rd_prev_reg && rd_ps_reg;
  wire standalone = sel_rd && ps_s; // RULE19
  wire in_cal = (state_reg == ahpc_pkg::st_cal);
  wire in_track = (state_reg == ahpc_pkg::st_track);
  wire in_conv = (state_reg == ahpc_pkg::st_conv);
  wire in_extra = (state_reg == ahpc_pkg::st_extra);
  wire decide = !clear && in_conv && tick;
  wire conv_start = !clear && in_track && !trim_lat_reg && tick && !hold_n_s;
  wire conv_fin = !clear && ((decide && bit_idx_reg == 4'h0 && !ilv_act) ||
                  (in_extra && extra_cnt_reg == 5'h00));
  wire cal_fin = !clear && in_cal &&
                 (burst_reg ? !trim_lat_reg : cal_cnt_reg == '0);
  wire finish = conv_fin || cal_fin;

  assign pos = 4'(16 - RES_BITS) + bit_idx_reg;

  // Internal conversion rate is mclk divided by four
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      div_reg <= 2'h0;
    else
      div_reg <= div_reg + 2'h1;
  end

  // Latches are transparent while selected, so tied-low select tracks pins
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      trim_lat_reg <= 1'b0;
      ilv_n_lat_reg <= 1'b1;
    end
    else if (!cs_n_s)
    begin
      trim_lat_reg <= cal_s; // RULE25
      ilv_n_lat_reg <= ilv_n_s; // RULE25
    end
  end

  // Sequencer: calibration, tracking, bit decisions, interleave experiment
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= ahpc_pkg::st_cal;
      cal_cnt_reg <= CW'(CAL_CYCLES - 1);
      burst_reg <= 1'b0;
      bit_idx_reg <= 4'h0;
      sar_reg <= 16'h0000;
      extra_cnt_reg <= 5'h00;
    end
    else if (clear)
    begin
      state_reg <= ahpc_pkg::st_cal; // RULE1
      cal_cnt_reg <= CW'(CAL_CYCLES - 1); // RULE27
      burst_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        ahpc_pkg::st_cal:
        begin
          if (cal_fin)
            state_reg <= ahpc_pkg::st_track;
          else if (!burst_reg)
            cal_cnt_reg <= cal_cnt_reg - CW'(1); // RULE1
        end
        ahpc_pkg::st_track:
        begin
          // Burst calibration runs only while the latched request is high
          if (trim_lat_reg)
          begin
            state_reg <= ahpc_pkg::st_cal;
            burst_reg <= 1'b1;
          end
          else if (conv_start)
          begin
            state_reg <= ahpc_pkg::st_conv;
            bit_idx_reg <= 4'(RES_BITS - 1);
            sar_reg <= 16'h0000;
          end
        end
        ahpc_pkg::st_conv:
        begin
          if (tick)
          begin
            sar_reg <= set_bit(sar_reg, pos, comp_s);
            if (bit_idx_reg != 4'h0)
              bit_idx_reg <= bit_idx_reg - 4'h1;
            else if (ilv_act)
            begin
              state_reg <= ahpc_pkg::st_extra; // RULE3
              extra_cnt_reg <= 5'(`AHPC_EXTRA_CYCLES - 1); // RULE4
            end
            else
              state_reg <= ahpc_pkg::st_track;
          end
        end
        ahpc_pkg::st_extra:
        begin
          if (extra_cnt_reg == 5'h00)
            state_reg <= ahpc_pkg::st_track;
          else
            extra_cnt_reg <= extra_cnt_reg - 5'h01; // RULE4
        end
        default:
          state_reg <= ahpc_pkg::st_cal;
      endcase
    end
  end

  // Trim update after a full set of interleaved experiments
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      trim_cnt_reg <= '0;
      trim_update_reg <= 1'b0;
    end
    else if (clear)
    begin
      trim_cnt_reg <= '0;
      trim_update_reg <= 1'b0;
    end
    else
    begin
      trim_update_reg <= 1'b0;
      if (conv_fin && in_extra)
      begin
        if (trim_cnt_reg == TW'(TRIM_CONVERSIONS - 1))
        begin
          trim_cnt_reg <= '0;
          trim_update_reg <= 1'b1; // RULE3
        end
        else
          trim_cnt_reg <= trim_cnt_reg + TW'(1);
      end
    end
  end

  // Output buffer decouples reads from the running conversion
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      result_reg <= `AHPC_RESULT_RESET;
    else if (conv_fin)
      result_reg <= in_conv ? set_bit(sar_reg, pos, comp_s) : sar_reg; // RULE18
  end

  // Read tracking; the byte pointer moves at the end of a read so a long
  // strobe never sees the byte change under it
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_prev_reg <= 1'b0;
      rd_ps_reg <= 1'b0;
      byte_ptr_reg <= 1'b1;
      done_flag_reg <= 1'b1;
    end
    else
    begin
      rd_prev_reg <= sel_rd;
      if (sel_rd)
        rd_ps_reg <= ps_s;
      if (clear || finish)
        byte_ptr_reg <= 1'b1; // RULE16
      else if (data_rd_end && !bw_s)
        byte_ptr_reg <= !byte_ptr_reg; // RULE17
      if (finish)
        done_flag_reg <= 1'b0; // RULE11
      else if (rd_start || clear)
        done_flag_reg <= 1'b1; // RULE11
    end
  end

  // End-of-convert: falls at completion, a conversion start or a data read
  // raises it; with the port held open it self-ends after four cycles
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      result_ready_n <= 1'b1;
      eoc_cnt_reg <= 2'h0;
    end
    else if (clear)
      result_ready_n <= 1'b1;
    else if (finish)
    begin
      result_ready_n <= 1'b0; // RULE9
      eoc_cnt_reg <= 2'h0;
    end
    else if (conv_start || data_rd)
      result_ready_n <= 1'b1; // RULE10
    else if (!result_ready_n)
    begin
      eoc_cnt_reg <= eoc_cnt_reg + 2'h1;
      if (standalone && eoc_cnt_reg == 2'(`AHPC_EOC_PULSE - 1))
        result_ready_n <= 1'b1; // RULE21
    end
  end

  // End-of-track counts off the settling time after completion
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acquired_n <= 1'b1;
      acq_cnt_reg <= 4'h0;
    end
    else if (clear || conv_start)
    begin
      acquired_n <= 1'b1;
      acq_cnt_reg <= 4'h0;
    end
    else if (finish)
    begin
      acquired_n <= 1'b1;
      acq_cnt_reg <= 4'(`AHPC_ACQ_CYCLES);
    end
    else if (acq_cnt_reg == 4'h1)
    begin
      acquired_n <= 1'b0; // RULE26
      acq_cnt_reg <= 4'h0;
    end
    else if (acq_cnt_reg != 4'h0)
      acq_cnt_reg <= acq_cnt_reg - 4'h1;
  end

  always_comb
  begin
    status = 8'h00; // RULE28
    status[`AHPC_ST_DONE] = done_flag_reg;
    status[`AHPC_ST_BYTE] = byte_ptr_reg; // RULE13
    status[`AHPC_ST_ACQ] = acquired_n; // RULE14
    status[`AHPC_ST_TRACK] = in_track; // RULE14
    status[`AHPC_ST_CONV] = in_conv || in_extra; // RULE14
    status[`AHPC_ST_CAL] = in_cal; // RULE14
  end

  // Bus drivers; enable is low while the port drives
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      data_oe_n <= 1'b1;
      data_out <= 16'h0000;
    end
    else
    begin
      data_oe_n <= !sel_rd; // RULE6
      if (!ps_s)
        data_out <= {8'h00, status}; // RULE6 RULE12
      else if (bw_s)
        data_out <= result_reg; // RULE15
      else if (byte_ptr_reg)
        data_out <= {8'h00, result_reg[15:8]}; // RULE16
      else
        data_out <= {8'h00, result_reg[7:0]}; // RULE16
    end
  end

  ahpc_serial_out #(
    .DELAY(`AHPC_SER_DELAY)
  ) u_serial (
    .mclk(mclk),
    .rst_n(rst_n),
    .bit_valid(decide),
    .bit_value(comp_s),
    .serial_bit_out(serial_bit_out),
    .bit_strobe_out(bit_strobe_out)
  );

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  clear_starts_cal_a: // RULE1
    assert property (clear |=> in_cal && cal_cnt_reg == CW'(CAL_CYCLES - 1)
      && status[`AHPC_ST_CAL])
    else $error("reset did not restart calibration");

  cal_end_ready_a: // RULE1
    assert property (in_cal && !burst_reg && cal_cnt_reg == '0 && !clear
      |=> in_track && !result_ready_n)
    else $error("calibration end not signalled");

  extra_cycles_a: // RULE4
    assert property (disable iff (!rst_n || clear)
      $rose(in_extra) |-> ##19 in_extra ##1 (in_track && !result_ready_n))
    else $error("interleave experiment not twenty cycles");

  soft_reset_a: // RULE8
    assert property (!cs_n_s && !ps_s && !hold_n_s |=> in_cal)
    else $error("status read under hold did not reset");

  drive_port_a: // RULE6
    assert property (sel_rd |=> !data_oe_n &&
      ($past(ps_s) || data_out[7:0] == $past(status)))
    else $error("selected read did not drive the port");

  reserved_zero_a: // RULE28
    assert property (!ps_s |=> data_out[`AHPC_ST_RSV1] == 1'b0 &&
      data_out[`AHPC_ST_RSV4] == 1'b0 && data_out[15:8] == 8'h00)
    else $error("reserved status bits not zero");

  ready_read_rise_a: // RULE10
    assert property (!result_ready_n && data_rd && !finish && !clear
      |-> ##[1:4] result_ready_n)
    else $error("ready not raised after data read");

  standalone_pulse_a: // RULE21
    assert property ($fell(result_ready_n) ##0
      (standalone && hold_n_s && !clear)[*4] |=> result_ready_n)
    else $error("standalone ready pulse not four cycles");

  acquire_delay_a: // RULE26
    assert property (disable iff (!rst_n || clear || conv_start)
      $fell(result_ready_n) |-> ##15 $fell(acquired_n))
    else $error("acquired not fifteen cycles after ready");

  byte_toggle_a: // RULE17
    assert property (data_rd_end && !bw_s && !finish && !clear
      |=> byte_ptr_reg != $past(byte_ptr_reg))
    else $error("byte pointer did not alternate");

  high_byte_first_a: // RULE16
    assert property (finish |=> byte_ptr_reg && !done_flag_reg)
    else $error("completion did not select upper byte");

  trim_update_a: // RULE3
    assert property (trim_update_reg |-> trim_cnt_reg == '0 && in_track)
    else $error("trim update out of sequence");

  conv_done_c: cover property (conv_fin ##[1:40] data_rd);
  byte_pair_c: cover property (data_rd_end && !bw_s ##[1:20] data_rd_end);
  trim_done_c: cover property (trim_update_reg);
  soft_reset_c: cover property (soft_rst && in_conv);

endmodule : ahpc_ctrl

/* bench/ahpc_latch_model.sv */
// Far-side latch logic: captures parallel words and serial bits.
// Assumes the port outputs are registered on mclk.
`timescale 1ns/1ns
module ahpc_latch_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Port outputs
  input wire logic [15:0] data_out,
  input wire logic result_ready_n,
  input wire logic serial_bit_out,
  input wire logic bit_strobe_out,
  // Captured values
  output logic [15:0] word_reg,
  output logic [15:0] ser_reg
);
  logic rdy_d_reg;
  logic stb_d_reg;
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdy_d_reg <= 1'h1;
      stb_d_reg <= 1'h1;
    end
    else
    begin
      rdy_d_reg <= result_ready_n;
      stb_d_reg <= bit_strobe_out;
    end
  end
  // Data settles late after ready falls, so latch only on its rise
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      word_reg <= 16'h0000;
    else if (result_ready_n && !rdy_d_reg)
      word_reg <= data_out;
  end
  // Last sixteen strobed bits hold the latest result, MSB first
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      ser_reg <= 16'h0000;
    else if (bit_strobe_out && !stb_d_reg)
      ser_reg <= {ser_reg[14:0], serial_bit_out};
  end
endmodule : ahpc_latch_model

/* bench/tb_adc_host_port_cal_control.sv */
// Testbench of the converter host port with a latch-logic far side.
// Assumes shortened calibration counts; pins change on falling edges.
`timescale 1ns/1ns
module tb_adc_host_port_cal_control;
  localparam int RB = 16;
  logic mclk, rst_n, hard_clear, device_select_n, output_strobe_n;
  logic port_select, sample_strobe_n, word_width_sel, trim_request;
  logic background_trim_n, comp_decision, data_oe_n, result_ready_n;
  logic acquired_n, serial_bit_out, bit_strobe_out;
  logic [15:0] data_out, word_reg, ser_reg, d, d2;
  int n_fail, n_checks, cyc, t1, dn, dn2, dl, v, k;

  ahpc_ctrl #(.RES_BITS(RB), .CAL_CYCLES(20), .TRIM_CONVERSIONS(3)) dut (
    .mclk, .rst_n, .hard_clear, .device_select_n, .output_strobe_n,
    .port_select, .sample_strobe_n, .word_width_sel, .trim_request,
    .background_trim_n, .comp_decision, .data_out, .data_oe_n,
    .result_ready_n, .acquired_n, .serial_bit_out, .bit_strobe_out);
  ahpc_latch_model far (.mclk, .rst_n, .data_out, .result_ready_n,
    .serial_bit_out, .bit_strobe_out, .word_reg, .ser_reg);

  initial
  begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) cyc++;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [15:0] exp_dur(input bit ilv);
    return 16'(4 * RB + (ilv ? 20 : 0));
  endfunction : exp_dur

  task automatic print_verdict();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  // Bounded wait on ready (which=0) or acquired (which=1)
  task automatic wait_pin(input bit which, input logic lvl);
    int i;
    for (i = 0; i < 3000 && (which ? acquired_n : result_ready_n) !== lvl;
         i++)
      @(negedge mclk);
    if (i == 3000)
      check(16'h0000, 16'h0001);
  endtask : wait_pin

  task automatic rd(input logic port, output logic [15:0] q);
    int i;
    @(negedge mclk);
    device_select_n = 1'h0;
    output_strobe_n = 1'h0;
    port_select = port;
    for (i = 0; i < 20 && data_oe_n !== 1'h0; i++)
      @(negedge mclk);
    check(data_oe_n, 1'h0);
    q = data_out;
    @(negedge mclk);
    if (port)
      check(result_ready_n, 1'h1);
    device_select_n = 1'h1;
    output_strobe_n = 1'h1;
    repeat (5) @(negedge mclk);
  endtask : rd

  task automatic cal_done();
    rd(1'h0, d);
    check(d[7], 1'h1);
    wait_pin(0, 1'h0);
    wait_pin(1, 1'h0);
    rd(1'h1, d);
  endtask : cal_done

  task automatic conv(input logic b, input bit flip);
    logic [15:0] q;
    @(negedge mclk);
    comp_decision = b;
    sample_strobe_n = 1'h0;
    wait_pin(1, 1'h1);
    t1 = cyc;
    sample_strobe_n = 1'h1;
    if (flip)
    begin
      repeat (30) @(negedge mclk);
      comp_decision = ~b;
      rd(1'h0, q);
      check(q & 16'h0040, 16'h0040);
    end
    wait_pin(0, 1'h0);
    dn = cyc - t1;
    t1 = cyc;
    for (dl = 0; dl < 10 && result_ready_n === 1'h0; dl++)
      @(negedge mclk);
    wait_pin(1, 1'h0);
    check(16'(cyc - t1), 16'h000F);
  endtask : conv

  // Starts a conversion, then pulls reset by hard clear or by the select,
  // port, hold combination while it runs
  task automatic reset_kind(input bit hard);
    @(negedge mclk);
    sample_strobe_n = 1'h0;
    repeat (8) @(negedge mclk);
    if (hard)
      hard_clear = 1'h1;
    else
      {device_select_n, port_select, sample_strobe_n} = 3'h0;
    repeat (5) @(negedge mclk);
    {hard_clear, device_select_n, port_select, sample_strobe_n} = 4'h7;
    cal_done();
  endtask : reset_kind

  initial
  begin
    {hard_clear, comp_decision, rst_n} = 3'h0;
    trim_request = 1'h0;
    {device_select_n, output_strobe_n, port_select} = 3'h7;
    {sample_strobe_n, word_width_sel, background_trim_n} = 3'h7;
    void'($urandom(90633));
    repeat (20) @(negedge mclk);
    rst_n = 1'h1;
    cal_done();
    for (k = 0; k < 4; k++)
    begin
      v = $urandom_range(1);
      conv(v[0], 1);
      check(dn >= exp_dur(0) - 2 && dn <= exp_dur(0) + 2, 1'h1);
      check(16'(dl), 16'h000A);
      rd(1'h1, d);
      check(d[15:9], {7{v[0]}});
      check(d[6:0], {7{~v[0]}});
      check(ser_reg, d);
      rd(1'h0, d2);
      check(d2 & 16'hFFFA, 16'h0020);
      check(d2[0], 1'h1);
    end
    word_width_sel = 1'h0;
    v = $urandom_range(1);
    conv(v[0], 1);
    rd(1'h0, d);
    check(d[2], 1'h1);
    rd(1'h1, d);
    check(d[7:1], {7{v[0]}});
    rd(1'h0, d2);
    check(d2[2], 1'h0);
    rd(1'h1, d2);
    check(d2[6:0], {7{~v[0]}});
    rd(1'h1, d2);
    check(d2, d);
    word_width_sel = 1'h1;
    reset_kind(0);
    reset_kind(1);
    @(negedge mclk);
    {device_select_n, output_strobe_n} = 2'h0;
    v = $urandom_range(1);
    conv(v[0], 0);
    check(16'(dl), 16'h0004);
    check(word_reg, {16{v[0]}});
    check(data_oe_n, 1'h0);
    dn2 = dn;
    background_trim_n = 1'h0;
    for (k = 0; k < 4; k++)
    begin
      conv(k[0], 0);
      check(16'(dn - dn2), exp_dur(1) - exp_dur(0));
    end
    print_verdict();
  end

  initial
  begin
    #300000;
    n_fail++;
    print_verdict();
  end
endmodule : tb_adc_host_port_cal_control
